//--- src/sid_input_decoder.sv
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "sid_regs.svh"
module sid_input_decoder
  import sid_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  terminalIn,
  output logic [7:0]       torqueCmd,
  output logic [1:0]       torqueBufIdx,
  output logic [15:0]      speedLimit,
  output logic             fbOpticalScale,
  output logic             jogForward,
  output logic             jogReverse,
  output logic             haltActive
);

  // ========================================================================
  // Software registers and bus state
  logic [31:0] ctrl_reg,     ctrl_next;
  logic [31:0] assignLo_reg, assignLo_next;
  logic [31:0] assignHi_reg, assignHi_next;
  logic [31:0] trqBuf_reg,   trqBuf_next;
  logic [31:0] trgEdge_reg,  trgEdge_next;
  logic [31:0] spdLimA_reg,  spdLimA_next;
  logic [31:0] spdLimB_reg,  spdLimB_next;
  sid_wr_t     wState_reg,   wState_next;
  sid_rd_t     rState_reg,   rState_next;
  logic        awHave_reg,   awHave_next;
  logic [7:0]  awAddr_reg,   awAddr_next;
  logic        wHave_reg,    wHave_next;
  logic [31:0] wData_reg,    wData_next;
  logic [3:0]  wStrb_reg,    wStrb_next;
  logic        awReady_reg,  awReady_next;
  logic        wReady_reg,   wReady_next;
  logic        bValid_reg,   bValid_next;
  logic [1:0]  bResp_reg,    bResp_next;
  logic        arReady_reg,  arReady_next;
  logic        rValid_reg,   rValid_next;
  logic [31:0] rData_reg,    rData_next;
  logic [1:0]  rResp_reg,    rResp_next;

  // ========================================================================
  // Decoder state
  logic [7:0]  termSample_reg, termSample_next;
  logic        trgPrev_reg,    trgPrev_next;
  logic [1:0]  bufIdx_reg,     bufIdx_next;
  logic [7:0]  torque_reg,     torque_next;
  logic [15:0] spdLim_reg,     spdLim_next;
  logic        fbScale_reg,    fbScale_next;
  logic        jogF_reg,       jogF_next;
  logic        jogR_reg,       jogR_next;
  logic        halt_reg,       halt_next;

  logic [63:0] assignAll;
  logic [7:0]  termFunc [8];
  logic [7:0]  funcLvl;
  sid_mode_t   curMode;
  sid_edge_t   edgeSel;
  logic [31:0] rdMux;
  logic        rdErr;
  logic [7:0]  wrAddr;
  logic [7:0]  rdAddr;

  function automatic logic [31:0] mergeStrb(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ========================================================================
  // Terminal routing
  assign assignAll = {assignHi_reg, assignLo_reg};
  assign curMode   = sid_mode_t'(ctrl_reg[`SID_CTRL_MODE_MSB:`SID_CTRL_MODE_LSB]);
  assign edgeSel   = sid_edge_t'(trgEdge_reg[1:0]);

  for (genvar t = 0; t < 8; t++) begin : g_term
    logic [7:0] code;
    assign code = assignAll[8*t +: 8];
    for (genvar f = 0; f < 8; f++) begin : g_fn
      assign termFunc[t][f] = termSample_reg[t] && (code == `SID_FN_BASE + 8'(f));
    end
  end

  // Several terminals on one function are ORed; unknown codes are ignored
  always_comb begin
    funcLvl = 8'h00;
    for (int t = 0; t < 8; t++) begin
      funcLvl = funcLvl | termFunc[t];
    end
  end

  // ========================================================================
  // Function decode
  always_comb begin
    logic trqMode;
    logic trgLvl;
    logic fire;
    trqMode = (curMode == SID_MODE_TRQ);
    trgLvl  = trqMode && funcLvl[`SID_FN_IDX_TRG];
    fire    = 1'b0;
    termSample_next = terminalIn;
    trgPrev_next    = trgLvl;
    bufIdx_next     = bufIdx_reg;
    torque_next     = torque_reg;
    if (trqMode) begin
      bufIdx_next = {funcLvl[`SID_FN_IDX_SEL1], funcLvl[`SID_FN_IDX_SEL0]};
    end
    case (edgeSel)
      SID_EDGE_LEVEL: fire = trgLvl;
      SID_EDGE_RISE:  fire = trgLvl && !trgPrev_reg;
      SID_EDGE_FALL:  fire = !trgLvl && trgPrev_reg && trqMode;
      SID_EDGE_BOTH:  fire = (trgLvl != trgPrev_reg) && trqMode;
      default:        fire = 1'b0;
    endcase
    if (fire) begin
      torque_next = trqBuf_reg[8*bufIdx_next +: 8];
    end
    // Outside torque mode the source input is ignored and limit A stands
    if (trqMode && funcLvl[`SID_FN_IDX_SLMT]) begin
      spdLim_next = spdLimB_reg[15:0];
    end else begin
      spdLim_next = spdLimA_reg[15:0];
    end
    fbScale_next = (curMode == SID_MODE_POS) && ctrl_reg[`SID_CTRL_FCL_BIT]
                   && funcLvl[`SID_FN_IDX_FBK];
    halt_next = funcLvl[`SID_FN_IDX_HALT];
    // Halt overrides jog, and opposing jog requests cancel to a stop
    jogF_next = (curMode != SID_MODE_NONE) && funcLvl[`SID_FN_IDX_JOGF]
                && !funcLvl[`SID_FN_IDX_JOGR] && !halt_next;
    jogR_next = (curMode != SID_MODE_NONE) && funcLvl[`SID_FN_IDX_JOGR]
                && !funcLvl[`SID_FN_IDX_JOGF] && !halt_next;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      termSample_reg <= 8'h00;
      trgPrev_reg    <= 1'b0;
      bufIdx_reg     <= 2'h0;
      torque_reg     <= 8'h00;
      spdLim_reg     <= 16'h0000;
      fbScale_reg    <= 1'b0;
      jogF_reg       <= 1'b0;
      jogR_reg       <= 1'b0;
      halt_reg       <= 1'b0;
    end else begin
      termSample_reg <= termSample_next;
      trgPrev_reg    <= trgPrev_next;
      bufIdx_reg     <= bufIdx_next;
      torque_reg     <= torque_next;
      spdLim_reg     <= spdLim_next;
      fbScale_reg    <= fbScale_next;
      jogF_reg       <= jogF_next;
      jogR_reg       <= jogR_next;
      halt_reg       <= halt_next;
    end
  end

  // ========================================================================
  // Read decode
  assign rdAddr = {s_axi_araddr[7:2], 2'b00};
  assign wrAddr = {awAddr_reg[7:2], 2'b00};

  always_comb begin
    rdErr = 1'b0;
    case (rdAddr)
      `SID_OFF_CTRL:      rdMux = {29'h0, ctrl_reg[2:0]};
      `SID_OFF_ASSIGN_LO: rdMux = assignLo_reg;
      `SID_OFF_ASSIGN_HI: rdMux = assignHi_reg;
      `SID_OFF_TRQ_BUF:   rdMux = trqBuf_reg;
      `SID_OFF_TRG_EDGE:  rdMux = {30'h0, trgEdge_reg[1:0]};
      `SID_OFF_SPD_LIM_A: rdMux = {16'h0, spdLimA_reg[15:0]};
      `SID_OFF_SPD_LIM_B: rdMux = {16'h0, spdLimB_reg[15:0]};
      `SID_OFF_STATUS:    rdMux = {10'h0, halt_reg, jogR_reg, jogF_reg, fbScale_reg,
                                   bufIdx_reg, torque_reg, funcLvl};
      default: begin
        rdMux = 32'h0000_0000;
        rdErr = 1'b1;
      end
    endcase
  end

  // ========================================================================
  // AXI4-Lite slave
  always_comb begin
    ctrl_next     = ctrl_reg;
    assignLo_next = assignLo_reg;
    assignHi_next = assignHi_reg;
    trqBuf_next   = trqBuf_reg;
    trgEdge_next  = trgEdge_reg;
    spdLimA_next  = spdLimA_reg;
    spdLimB_next  = spdLimB_reg;
    wState_next   = wState_reg;
    rState_next   = rState_reg;
    awHave_next   = awHave_reg;
    awAddr_next   = awAddr_reg;
    wHave_next    = wHave_reg;
    wData_next    = wData_reg;
    wStrb_next    = wStrb_reg;
    bValid_next   = bValid_reg;
    bResp_next    = bResp_reg;
    arReady_next  = arReady_reg;
    rValid_next   = rValid_reg;
    rData_next    = rData_reg;
    rResp_next    = rResp_reg;
    case (wState_reg)
      SID_W_IDLE: begin
        if (s_axi_awvalid && awReady_reg) begin
          awHave_next = 1'b1;
          awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wReady_reg) begin
          wHave_next = 1'b1;
          wData_next = s_axi_wdata;
          wStrb_next = s_axi_wstrb;
        end
        if (awHave_reg && wHave_reg) begin
          awHave_next = 1'b0;
          wHave_next  = 1'b0;
          bValid_next = 1'b1;
          bResp_next  = `SID_RESP_OKAY;
          wState_next = SID_W_RESP;
          case (wrAddr)
            `SID_OFF_CTRL:      ctrl_next     = mergeStrb(ctrl_reg, wData_reg, wStrb_reg);
            `SID_OFF_ASSIGN_LO: assignLo_next = mergeStrb(assignLo_reg, wData_reg, wStrb_reg);
            `SID_OFF_ASSIGN_HI: assignHi_next = mergeStrb(assignHi_reg, wData_reg, wStrb_reg);
            `SID_OFF_TRQ_BUF:   trqBuf_next   = mergeStrb(trqBuf_reg, wData_reg, wStrb_reg);
            `SID_OFF_TRG_EDGE:  trgEdge_next  = mergeStrb(trgEdge_reg, wData_reg, wStrb_reg);
            `SID_OFF_SPD_LIM_A: spdLimA_next  = mergeStrb(spdLimA_reg, wData_reg, wStrb_reg);
            `SID_OFF_SPD_LIM_B: spdLimB_next  = mergeStrb(spdLimB_reg, wData_reg, wStrb_reg);
            `SID_OFF_STATUS:    bResp_next    = `SID_RESP_OKAY;
            default:            bResp_next    = `SID_RESP_SLVERR;
          endcase
        end
      end
      SID_W_RESP: begin
        if (s_axi_bready) begin
          bValid_next = 1'b0;
          wState_next = SID_W_IDLE;
        end
      end
      default: wState_next = SID_W_IDLE;
    endcase
    // Readies are registered, so each half is taken at most once per write
    awReady_next = (wState_next == SID_W_IDLE) && !awHave_next;
    wReady_next  = (wState_next == SID_W_IDLE) && !wHave_next;
    case (rState_reg)
      SID_R_IDLE: begin
        if (s_axi_arvalid && arReady_reg) begin
          rData_next   = rdMux;
          rResp_next   = rdErr ? `SID_RESP_SLVERR : `SID_RESP_OKAY;
          rValid_next  = 1'b1;
          arReady_next = 1'b0;
          rState_next  = SID_R_DATA;
        end else if (!arReady_reg) begin
          arReady_next = 1'b1;
        end
      end
      SID_R_DATA: begin
        if (s_axi_rready) begin
          rValid_next  = 1'b0;
          arReady_next = 1'b1;
          rState_next  = SID_R_IDLE;
        end
      end
      default: rState_next = SID_R_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg     <= `SID_RST_CTRL;
      assignLo_reg <= `SID_RST_ASSIGN_LO;
      assignHi_reg <= `SID_RST_ASSIGN_HI;
      trqBuf_reg   <= `SID_RST_TRQ_BUF;
      trgEdge_reg  <= `SID_RST_TRG_EDGE;
      spdLimA_reg  <= `SID_RST_SPD_LIM;
      spdLimB_reg  <= `SID_RST_SPD_LIM;
      wState_reg   <= SID_W_IDLE;
      rState_reg   <= SID_R_IDLE;
      awHave_reg   <= 1'b0;
      awAddr_reg   <= 8'h00;
      wHave_reg    <= 1'b0;
      wData_reg    <= 32'h0000_0000;
      wStrb_reg    <= 4'h0;
      awReady_reg  <= 1'b0;
      wReady_reg   <= 1'b0;
      bValid_reg   <= 1'b0;
      bResp_reg    <= `SID_RESP_OKAY;
      arReady_reg  <= 1'b0;
      rValid_reg   <= 1'b0;
      rData_reg    <= 32'h0000_0000;
      rResp_reg    <= `SID_RESP_OKAY;
    end else begin
      ctrl_reg     <= ctrl_next;
      assignLo_reg <= assignLo_next;
      assignHi_reg <= assignHi_next;
      trqBuf_reg   <= trqBuf_next;
      trgEdge_reg  <= trgEdge_next;
      spdLimA_reg  <= spdLimA_next;
      spdLimB_reg  <= spdLimB_next;
      wState_reg   <= wState_next;
      rState_reg   <= rState_next;
      awHave_reg   <= awHave_next;
      awAddr_reg   <= awAddr_next;
      wHave_reg    <= wHave_next;
      wData_reg    <= wData_next;
      wStrb_reg    <= wStrb_next;
      awReady_reg  <= awReady_next;
      wReady_reg   <= wReady_next;
      bValid_reg   <= bValid_next;
      bResp_reg    <= bResp_next;
      arReady_reg  <= arReady_next;
      rValid_reg   <= rValid_next;
      rData_reg    <= rData_next;
      rResp_reg    <= rResp_next;
    end
  end

  assign s_axi_awready  = awReady_reg;
  assign s_axi_wready   = wReady_reg;
  assign s_axi_bvalid   = bValid_reg;
  assign s_axi_bresp    = bResp_reg;
  assign s_axi_arready  = arReady_reg;
  assign s_axi_rvalid   = rValid_reg;
  assign s_axi_rdata    = rData_reg;
  assign s_axi_rresp    = rResp_reg;
  assign torqueCmd      = torque_reg;
  assign torqueBufIdx   = bufIdx_reg;
  assign speedLimit     = spdLim_reg;
  assign fbOpticalScale = fbScale_reg;
  assign jogForward     = jogF_reg;
  assign jogReverse     = jogR_reg;
  assign haltActive     = halt_reg;

endmodule

//--- src/sid_pkg.sv
package sid_pkg;

  typedef enum logic [1:0] {
    SID_MODE_POS  = 2'h0,
    SID_MODE_SPD  = 2'h1,
    SID_MODE_TRQ  = 2'h2,
    SID_MODE_NONE = 2'h3
  } sid_mode_t;

  typedef enum logic [1:0] {
    SID_EDGE_LEVEL = 2'h0,
    SID_EDGE_RISE  = 2'h1,
    SID_EDGE_FALL  = 2'h2,
    SID_EDGE_BOTH  = 2'h3
  } sid_edge_t;

  typedef enum logic {
    SID_W_IDLE = 1'b0,
    SID_W_RESP = 1'b1
  } sid_wr_t;

  typedef enum logic {
    SID_R_IDLE = 1'b0,
    SID_R_DATA = 1'b1
  } sid_rd_t;

endpackage

//--- src/sid_regs.svh
`ifndef SID_REGS_SVH
`define SID_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define SID_OFF_CTRL      8'h00
`define SID_OFF_ASSIGN_LO 8'h04
`define SID_OFF_ASSIGN_HI 8'h08
`define SID_OFF_TRQ_BUF   8'h0C
`define SID_OFF_TRG_EDGE  8'h10
`define SID_OFF_SPD_LIM_A 8'h14
`define SID_OFF_SPD_LIM_B 8'h18
`define SID_OFF_STATUS    8'h1C

// ==========================================================================
// Field positions
`define SID_CTRL_MODE_MSB 1
`define SID_CTRL_MODE_LSB 0
`define SID_CTRL_FCL_BIT  2

// ==========================================================================
// Input function assignment codes
`define SID_FN_BASE     8'h12
`define SID_FN_TRQ_SEL0 3
`define SID_FN_IDX_SEL0 0
`define SID_FN_IDX_SEL1 1
`define SID_FN_IDX_TRG  2
`define SID_FN_IDX_SLMT 3
`define SID_FN_IDX_FBK  4
`define SID_FN_IDX_JOGF 5
`define SID_FN_IDX_JOGR 6
`define SID_FN_IDX_HALT 7

// ==========================================================================
// Reset values
`define SID_RST_CTRL      32'h0000_0000
`define SID_RST_ASSIGN_LO 32'h1514_1312
`define SID_RST_ASSIGN_HI 32'h1918_1716
`define SID_RST_TRQ_BUF   32'h0000_0000
`define SID_RST_TRG_EDGE  32'h0000_0001
`define SID_RST_SPD_LIM   32'h0000_0000

// ==========================================================================
// Bus responses
`define SID_RESP_OKAY   2'h0
`define SID_RESP_SLVERR 2'h2

`endif

//--- test/sid_host_model.sv
`timescale 1ns/10ps
// Host controller: terminal levels change only just after a clock edge
module sid_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] pinsWant,
  output logic      [7:0] terminalIn
);
  logic [7:0] pins_reg = 8'h00;
  logic [7:0] pins_next;
  always_comb begin
    pins_next = pinsWant;
  end
  always_ff @(posedge core_clk) begin
    pins_reg <= pins_next;
  end
  assign terminalIn = pins_reg;
endmodule

//--- test/sid_input_decoder_checker.sv
`timescale 1ns/10ps
module sid_input_decoder_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  terminalIn,
  input wire logic [7:0]  torqueCmd,
  input wire logic [1:0]  torqueBufIdx,
  input wire logic        fbOpticalScale,
  input wire logic        jogForward,
  input wire logic        jogReverse,
  input wire logic        haltActive
);
  // ==========================================================
  // Warm-up: $past must not look back into a reset
  logic [1:0] rstAge_reg;
  logic [1:0] rstAge_next;
  logic       warm;
  always_comb begin
    rstAge_next = rst ? 2'h0 : ((rstAge_reg == 2'h3) ? 2'h3 : rstAge_reg + 2'h1);
  end
  always_ff @(posedge core_clk) begin
    rstAge_reg <= rstAge_next;
  end
  assign warm = (rstAge_reg == 2'h3);

  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_halt_level: assert property (warm |-> haltActive == $past(terminalIn[7], 2))
    else $error("halt output does not follow its terminal");
  a_halt_masks_jog: assert property (haltActive |-> !jogForward && !jogReverse)
    else $error("jog active during halt");
  a_jog_fwd_cause: assert property (jogForward |-> $past(terminalIn[5], 2))
    else $error("forward jog without its terminal");
  a_jog_rev_cause: assert property (jogReverse |-> $past(terminalIn[6], 2))
    else $error("reverse jog without its terminal");
  a_fb_change: assert property (warm && $changed(fbOpticalScale) |->
    fbOpticalScale == $past(terminalIn[4], 2)) else $error("feedback source moved wrongly");
  a_buf_index: assert property (warm && $changed(torqueBufIdx) |->
    torqueBufIdx == {$past(terminalIn[1], 2), $past(terminalIn[0], 2)})
    else $error("buffer index differs from select terminals");
  a_trq_trigger: assert property (warm && $changed(torqueCmd) |->
    $past(terminalIn[2], 2) || $past(terminalIn[2], 3)) else $error("torque changed untriggered");
  // Both halves land one edge, the register and response follow one edge later
  a_wr_answer: assert property (s_wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write response late or ready not dropped");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

bind sid_input_decoder sid_input_decoder_checker u_chk (
  .core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .terminalIn, .torqueCmd, .torqueBufIdx,
  .fbOpticalScale, .jogForward, .jogReverse, .haltActive
);

//--- test/tb.sv
`timescale 1ns/10ps
`include "sid_regs.svh"
module tb;
  logic        core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, fbOpticalScale, jogForward, jogReverse, haltActive;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, terminalIn, pinsWant, torqueCmd;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, torqueBufIdx, rsp;
  logic [15:0] speedLimit;
  int          failures, n_compared;

  sid_input_decoder u_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .terminalIn, .torqueCmd, .torqueBufIdx, .speedLimit,
    .fbOpticalScale, .jogForward, .jogReverse, .haltActive);
  sid_host_model u_host (.core_clk, .pinsWant, .terminalIn);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ==========================================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task final_report;
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Late bready and rready keep the standing-answer checks exercised
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    @(posedge core_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge core_clk);
    s_axi_rready <= 1'b1;
    @(posedge core_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Two edges through the decoder plus one through the host model
  task setp(input logic [7:0] v);
    @(posedge core_clk);
    pinsWant <= v;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // ==========================================================
  // Tests
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, pinsWant, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    failures = 0;
    n_compared = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rdr(`SID_OFF_ASSIGN_LO, rd, rsp);
    chk(rd, `SID_RST_ASSIGN_LO);
    rdr(`SID_OFF_ASSIGN_HI, rd, rsp);
    chk(rd, `SID_RST_ASSIGN_HI);
    rdr(`SID_OFF_TRG_EDGE, rd, rsp);
    chk(rd, `SID_RST_TRG_EDGE);
    rdr(8'h20, rd, rsp);
    chk({rd[31:2], rsp}, 32'(`SID_RESP_SLVERR));
    wr(8'h24, 32'hFFFF_FFFF, rsp);
    chk(32'(rsp), 32'(`SID_RESP_SLVERR));
    wr(`SID_OFF_TRQ_BUF, 32'h4433_2211, rsp);
    wr(`SID_OFF_SPD_LIM_A, 32'h0000_1234, rsp);
    wr(`SID_OFF_SPD_LIM_B, 32'h0000_5678, rsp);
    wr(`SID_OFF_CTRL, 32'(sid_pkg::SID_MODE_TRQ), rsp);
    for (int c = 0; c < 4; c++) begin
      setp(8'(c));
      chk(32'(torqueCmd), 32'h11 * c);
      chk(32'(torqueBufIdx), 32'(c));
      setp(8'(c) | 8'h04);
      chk(32'(torqueCmd), 32'h11 * (c + 1));
    end
    wr(`SID_OFF_TRG_EDGE, 32'(sid_pkg::SID_EDGE_FALL), rsp);
    setp(8'h01);
    chk(32'(torqueCmd), 32'h22);
    setp(8'h05);
    chk(32'(torqueCmd), 32'h22);
    wr(`SID_OFF_TRG_EDGE, 32'(sid_pkg::SID_EDGE_LEVEL), rsp);
    setp(8'h04);
    chk(32'(torqueCmd), 32'h11);
    setp(8'h00);
    chk(32'(speedLimit), 32'h1234);
    setp(8'h08);
    chk(32'(speedLimit), 32'h5678);
    wr(`SID_OFF_CTRL, 32'(sid_pkg::SID_MODE_POS), rsp);
    setp(8'h0F);
    chk({torqueCmd, 6'h0, torqueBufIdx, speedLimit}, 32'h1100_1234);
    wr(`SID_OFF_CTRL, 32'h0000_0004, rsp);
    setp(8'h10);
    chk(32'(fbOpticalScale), 32'h1);
    setp(8'h00);
    chk(32'(fbOpticalScale), 32'h0);
    wr(`SID_OFF_CTRL, 32'h0000_0006, rsp);
    setp(8'h10);
    chk(32'(fbOpticalScale), 32'h0);
    for (int m = 0; m < 3; m++) begin
      wr(`SID_OFF_CTRL, 32'(m), rsp);
      setp(8'h20);
      chk({30'h0, jogForward, jogReverse}, 32'h2);
      setp(8'h40);
      chk({30'h0, jogForward, jogReverse}, 32'h1);
    end
    // No control mode selected: jog requests have nothing to act on
    wr(`SID_OFF_CTRL, 32'(sid_pkg::SID_MODE_NONE), rsp);
    setp(8'h20);
    chk({30'h0, jogForward, jogReverse}, 32'h0);
    setp(8'hA0);
    chk({30'h0, haltActive, jogForward}, 32'h2);
    rdr(`SID_OFF_STATUS, rd, rsp);
    chk({rd[21], rd[7:0]}, 32'h1A0);
    setp(8'h00);
    chk(32'(haltActive), 32'h0);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rdr(`SID_OFF_CTRL, rd, rsp);
    chk(rd, `SID_RST_CTRL);
    final_report;
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    final_report;
  end
endmodule
